// ==== tf_pkg.sv ====
`default_nettype none

package tf_pkg;

  // ----------------------------------------------------------------
  // Register map (byte addresses on the APB)
  // ----------------------------------------------------------------
  localparam logic [7:0] OFF_FEATURE    = 8'h04;
  localparam logic [7:0] OFF_SEC_COUNT  = 8'h08;
  localparam logic [7:0] OFF_SEC_NUMBER = 8'h0C;
  localparam logic [7:0] OFF_CYL_LOW    = 8'h10;
  localparam logic [7:0] OFF_CYL_HIGH   = 8'h14;
  localparam logic [7:0] OFF_DRIVE_HEAD = 8'h18;
  localparam logic [7:0] OFF_STATUS     = 8'h1C;
  localparam logic [7:0] OFF_SHADOW     = 8'h38;
  localparam logic [7:0] OFF_ERROR      = 8'h24;
  localparam logic [7:0] OFF_DEV_CTRL   = 8'h3C;
  localparam logic [7:0] OFF_CMD_INFO   = 8'h40;
  localparam logic [7:0] OFF_MODE       = 8'h44;
  localparam logic [7:0] OFF_BACKEND    = 8'h48;
  localparam logic [7:0] OFF_LBA        = 8'h4C;
  localparam logic [7:0] OFF_COUNT      = 8'h50;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int ST_BUSY    = 7;
  localparam int ST_READY   = 6;
  localparam int ST_WFAULT  = 5;
  localparam int ST_SEEK    = 4;
  localparam int ST_DREQ    = 3;
  localparam int ST_CORRECTED = 2;
  localparam int ST_INDEX   = 1;
  localparam int ST_ERR     = 0;
  localparam int ER_ABORT   = 2;
  localparam int DC_SOFT_RESET = 2;
  localparam int DC_INT_OFF = 1;
  localparam int DH_LBA     = 6;
  localparam int DH_DRIVE   = 4;

  // Backend event bits (write 1 to pulse, own register)
  localparam int BE_DONE    = 0;
  localparam int BE_ERROR   = 1;
  localparam int BE_CORRECTED = 2;
  localparam int BE_WFAULT  = 3;
  localparam int BE_DREQ_ON = 4;
  localparam int BE_DREQ_OFF = 5;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_SEC_COUNT  = 8'h01;
  localparam logic [7:0] RST_SEC_NUMBER = 8'h01;
  localparam logic [7:0] RST_DRIVE_HEAD = 8'hA0;
  localparam logic [7:0] RST_DEV_CTRL   = 8'h08;

  // ----------------------------------------------------------------
  // Command codes
  // ----------------------------------------------------------------
  localparam logic [7:0] CMD_READ_SEC    = 8'h20;
  localparam logic [7:0] CMD_READ_SEC_NR = 8'h21;
  localparam logic [7:0] CMD_WRITE_SEC   = 8'h30;
  localparam logic [7:0] CMD_WRITE_SEC_NR = 8'h31;
  localparam logic [7:0] CMD_WRITE_NOERA = 8'h38;
  localparam logic [7:0] CMD_READ_MULT   = 8'hC4;
  localparam logic [7:0] CMD_WRITE_MULT  = 8'hC5;
  localparam logic [7:0] CMD_WMULT_NOERA = 8'hCD;
  localparam logic [7:0] CMD_SET_FEAT    = 8'hEF;
  localparam logic [3:0] CMD_SEEK_HI     = 4'h7;

  // Configuration index values that enable read-to-negate
  localparam logic [5:0] CFG_IDX_MIN = 6'h01;
  localparam logic [5:0] CFG_IDX_MAX = 6'h03;

  localparam logic [8:0] SEC_COUNT_ZERO = 9'h100;

  // Command class
  typedef enum logic [2:0] {
    CC_NONE   = 3'b000,
    CC_READ   = 3'b001,
    CC_WRITE  = 3'b010,
    CC_SEEK   = 3'b011,
    CC_FEAT   = 3'b100,
    CC_BAD    = 3'b111
  } cmd_class_t;

  // Decoded parameters handed to the back end
  typedef struct packed {
    logic [27:0] lba;
    logic [8:0]  count;
    logic [7:0]  feature;
    logic        drive;
    logic        lba_mode;
  } cmd_param_t;

endpackage : tf_pkg

`default_nettype wire

// ==== disk_task_file_status_control.sv ====
// Added by the designer: the APB slave port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none

// Function
// RULE1: Status read in level IO mode negates request
// RULE2: Host reads status bytewise, else shadow
// RULE3: Busy set while internal operation executes
// RULE4: Ready and seek-complete gate read/write/seek
// RULE5: Write fault sets status bit five
// RULE6: Seek complete sets status bit four
// RULE7: Data request shown, cleared on new command
// RULE8: Corrected data sets status bit two
// RULE9: Index bit always reads zero
// RULE10: Error bit set on failure, cleared next
// RULE11: Shadow status mirrors, never negates request
// RULE12: Host loads parameters then writes command
// RULE13: Decode sector read/write command codes
// RULE14: Decode multiple-sector command codes
// RULE15: Take only parameters valid per command
// RULE16: Control bits seven to four ignored
// RULE17: Soft reset holds task file until cleared
// RULE18: Interrupt disable bit gates request output
// RULE19: Form 28-bit logical block address
// RULE20: Sector count zero means 256 sectors
// RULE21: Abort flag set on aborted command
// RULE22: Completion raises request; unknown code aborts
module disk_task_file_status_control (
  input  wire  logic        pclk,
  input  wire  logic        presetn,
  input  wire  logic        psel,
  input  wire  logic        penable,
  input  wire  logic        pwrite,
  input  wire  logic [7:0]  paddr,
  input  wire  logic [31:0] pwdata,
  output logic              pready,
  output logic [31:0]       prdata,
  output logic              pslverr,
  output logic              interrupt_request_n,
  output logic              cmd_start,
  output tf_pkg::cmd_class_t cmd_kind,
  output tf_pkg::cmd_param_t cmd_param
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0]          feature;
    logic [7:0]          sec_count;
    logic [7:0]          sec_number;
    logic [7:0]          cyl_low;
    logic [7:0]          cyl_high;
    logic [7:0]          drive_head;
    logic [7:0]          error_r;
    logic                busy;
    logic                ready;
    logic                wfault;
    logic                seek_done;
    logic                dreq;
    logic                corrected;
    logic                err;
    logic                int_off;
    logic                soft_reset;
    logic                pending;
    logic [5:0]          cfg_index;
    logic                level_mode;
    logic                pready;
    logic [31:0]         prdata;
    logic                pslverr;
    logic                irq_n;
    logic                start;
    tf_pkg::cmd_class_t  kind;
    tf_pkg::cmd_param_t  param;
  } state_t;

  state_t s_r;
  state_t s_nxt;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Command class from code; unknown codes end in abort
  function automatic tf_pkg::cmd_class_t classify(input logic [7:0] code);
    tf_pkg::cmd_class_t c;
    c = tf_pkg::CC_BAD;
    case (code)
      tf_pkg::CMD_READ_SEC, tf_pkg::CMD_READ_SEC_NR,
      tf_pkg::CMD_READ_MULT:   c = tf_pkg::CC_READ;       // RULE13 RULE14
      tf_pkg::CMD_WRITE_SEC, tf_pkg::CMD_WRITE_SEC_NR,
      tf_pkg::CMD_WRITE_NOERA, tf_pkg::CMD_WRITE_MULT,
      tf_pkg::CMD_WMULT_NOERA: c = tf_pkg::CC_WRITE;      // RULE13 RULE14
      tf_pkg::CMD_SET_FEAT:    c = tf_pkg::CC_FEAT;
      default:
      begin
        // Any code of the seek row selects a seek
        if (code[7:4] == tf_pkg::CMD_SEEK_HI)
          c = tf_pkg::CC_SEEK;
      end
    endcase
    return c;
  endfunction : classify

  // Status byte shared by primary and shadow reads
  function automatic logic [7:0] status_byte(input state_t s);
    logic [7:0] b;
    b = 8'h00;
    b[tf_pkg::ST_BUSY]   = s.busy;       // RULE3
    b[tf_pkg::ST_READY]  = s.ready;
    b[tf_pkg::ST_WFAULT] = s.wfault;     // RULE5
    b[tf_pkg::ST_SEEK]   = s.seek_done;  // RULE6
    b[tf_pkg::ST_DREQ]   = s.dreq;
    b[tf_pkg::ST_CORRECTED] = s.corrected; // RULE8
    b[tf_pkg::ST_INDEX]  = 1'b0;         // RULE9
    b[tf_pkg::ST_ERR]    = s.err;
    return b;
  endfunction : status_byte

  // ----------------------------------------------------------------
  // Bus phase decode
  // ----------------------------------------------------------------
  // Only the setup cycle acts; the access cycle merely answers
  logic       setup;
  logic       wr;
  logic       rd;
  logic [7:0] wb;
  logic       io_level;

  assign setup    = psel && !penable;
  assign wr       = setup && pwrite;
  assign rd       = setup && !pwrite;
  assign wb       = pwdata[7:0];
  assign io_level = s_r.level_mode && (s_r.cfg_index >= tf_pkg::CFG_IDX_MIN)
                    && (s_r.cfg_index <= tf_pkg::CFG_IDX_MAX);

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  // The slave answers in the access cycle: data is latched in setup so
  // that pready and prdata come straight from flip-flops.
  always_comb
  begin
    tf_pkg::cmd_class_t c;
    logic               accept;
    logic [8:0]         cnt;
    s_nxt         = s_r;
    c             = tf_pkg::CC_NONE;
    accept        = 1'b0;
    cnt           = 9'h000;
    s_nxt.start   = 1'b0;
    s_nxt.pready  = setup;
    s_nxt.pslverr = 1'b0;
    // Read data stands in the access cycle only and reads zero otherwise
    s_nxt.prdata  = 32'h0000_0000;

    // Register reads
    if (rd)
    begin
      case (paddr)
        tf_pkg::OFF_SEC_COUNT:  s_nxt.prdata = {24'h000000, s_r.sec_count};
        tf_pkg::OFF_SEC_NUMBER: s_nxt.prdata = {24'h000000, s_r.sec_number};
        tf_pkg::OFF_CYL_LOW:    s_nxt.prdata = {24'h000000, s_r.cyl_low};
        tf_pkg::OFF_CYL_HIGH:   s_nxt.prdata = {24'h000000, s_r.cyl_high};
        tf_pkg::OFF_DRIVE_HEAD: s_nxt.prdata = {24'h000000, s_r.drive_head};
        tf_pkg::OFF_ERROR:      s_nxt.prdata = {24'h000000, s_r.error_r};
        tf_pkg::OFF_STATUS:
        begin
          s_nxt.prdata = {24'h000000, status_byte(s_r)};
          if (io_level)
            s_nxt.pending = 1'b0;                          // RULE1
        end
        tf_pkg::OFF_SHADOW:
          s_nxt.prdata = {24'h000000, status_byte(s_r)};   // RULE11 RULE2
        tf_pkg::OFF_MODE:
          s_nxt.prdata = {24'h000000, s_r.level_mode, 1'b0, s_r.cfg_index};
        tf_pkg::OFF_LBA:        s_nxt.prdata = {4'h0, s_r.param.lba};
        tf_pkg::OFF_COUNT:      s_nxt.prdata = {23'h000000, s_r.param.count};
        tf_pkg::OFF_CMD_INFO:
          s_nxt.prdata = {16'h0000, s_r.param.feature, 5'h00, s_r.kind};
        default:                s_nxt.pslverr = 1'b1;
      endcase
    end

    // Register writes
    if (wr)
    begin
      case (paddr)
        tf_pkg::OFF_FEATURE:    s_nxt.feature    = wb;
        tf_pkg::OFF_SEC_COUNT:  s_nxt.sec_count  = wb;
        tf_pkg::OFF_SEC_NUMBER: s_nxt.sec_number = wb;
        tf_pkg::OFF_CYL_LOW:    s_nxt.cyl_low    = wb;
        tf_pkg::OFF_CYL_HIGH:   s_nxt.cyl_high   = wb;
        tf_pkg::OFF_DRIVE_HEAD: s_nxt.drive_head = wb;
        tf_pkg::OFF_DEV_CTRL:
        begin
          s_nxt.soft_reset = wb[tf_pkg::DC_SOFT_RESET];    // RULE16 RULE17
          s_nxt.int_off    = wb[tf_pkg::DC_INT_OFF];       // RULE18
        end
        tf_pkg::OFF_MODE:
        begin
          s_nxt.cfg_index  = pwdata[5:0];
          s_nxt.level_mode = pwdata[7];
        end
        tf_pkg::OFF_STATUS:
        begin
          // Command write; ignored while busy, cleared flags on entry
          if (!s_r.busy && !s_r.soft_reset)
          begin
            c = classify(wb);
            s_nxt.dreq    = 1'b0;                          // RULE7
            s_nxt.err     = 1'b0;                          // RULE10
            s_nxt.error_r = 8'h00;
            s_nxt.pending = 1'b0;
            // Unknown codes and refused media commands end in abort
            accept = (c != tf_pkg::CC_BAD);
            if ((c == tf_pkg::CC_READ) || (c == tf_pkg::CC_WRITE) ||
                (c == tf_pkg::CC_SEEK))
              accept = s_r.ready && s_r.seek_done;         // RULE4
            if (accept)
            begin
              cnt = (s_r.sec_count == 8'h00) ? tf_pkg::SEC_COUNT_ZERO
                    : {1'b0, s_r.sec_count};               // RULE20
              s_nxt.busy  = 1'b1;                          // RULE3
              s_nxt.start = 1'b1;
              s_nxt.kind  = c;
              s_nxt.param = '0;
              s_nxt.param.drive = s_r.drive_head[tf_pkg::DH_DRIVE];
              // Seek complete drops until this seek is reported done
              if (c == tf_pkg::CC_SEEK)
                s_nxt.seek_done = 1'b0;                    // RULE6
              if (c == tf_pkg::CC_FEAT)
                s_nxt.param.feature = s_r.feature;         // RULE15
              if ((c == tf_pkg::CC_READ) || (c == tf_pkg::CC_WRITE))
                s_nxt.param.count = cnt;                   // RULE15
              if (c != tf_pkg::CC_FEAT)
              begin
                s_nxt.param.lba_mode = s_r.drive_head[tf_pkg::DH_LBA];
                s_nxt.param.lba = {s_r.drive_head[3:0], s_r.cyl_high,
                                   s_r.cyl_low, s_r.sec_number}; // RULE19
              end
            end
            else
            begin
              s_nxt.err = 1'b1;                            // RULE22
              s_nxt.error_r[tf_pkg::ER_ABORT] = 1'b1;      // RULE21
              s_nxt.pending = 1'b1;                        // RULE22
            end
          end
        end
        tf_pkg::OFF_BACKEND:
        begin
          // Back-end events; set wins over any clear in the same write
          if (pwdata[tf_pkg::BE_DREQ_OFF])
            s_nxt.dreq = 1'b0;
          if (pwdata[tf_pkg::BE_DREQ_ON])
            s_nxt.dreq = 1'b1;                             // RULE7
          if (pwdata[tf_pkg::BE_CORRECTED])
            s_nxt.corrected = 1'b1;                        // RULE8
          if (pwdata[tf_pkg::BE_WFAULT])
          begin
            s_nxt.wfault = 1'b1;                           // RULE5
            s_nxt.error_r[tf_pkg::ER_ABORT] = 1'b1;        // RULE21
            s_nxt.err = 1'b1;
          end
          if (pwdata[tf_pkg::BE_DONE] && s_r.busy)
          begin
            s_nxt.busy    = 1'b0;
            s_nxt.pending = 1'b1;                          // RULE22
            if (s_r.kind == tf_pkg::CC_SEEK)
              s_nxt.seek_done = 1'b1;                      // RULE6
            if (pwdata[tf_pkg::BE_ERROR])
              s_nxt.err = 1'b1;                            // RULE10
          end
        end
        default:                s_nxt.pslverr = 1'b1;
      endcase
    end

    // Soft reset holds task file; mode and control bits survive
    if (s_nxt.soft_reset)
    begin
      s_nxt.sec_count  = tf_pkg::RST_SEC_COUNT;            // RULE17
      s_nxt.sec_number = tf_pkg::RST_SEC_NUMBER;
      s_nxt.cyl_low    = 8'h00;
      s_nxt.cyl_high   = 8'h00;
      s_nxt.drive_head = tf_pkg::RST_DRIVE_HEAD;
      s_nxt.feature    = 8'h00;
      s_nxt.error_r    = 8'h00;
      s_nxt.busy       = 1'b1;
      s_nxt.ready      = 1'b0;
      s_nxt.wfault     = 1'b0;
      s_nxt.dreq       = 1'b0;
      s_nxt.corrected  = 1'b0;
      s_nxt.err        = 1'b0;
      s_nxt.pending    = 1'b0;
      s_nxt.kind       = tf_pkg::CC_NONE;
    end
    else if (s_r.soft_reset)
    begin
      // Release: the task file comes back ready with no seek pending
      s_nxt.busy      = 1'b0;
      s_nxt.ready     = 1'b1;
      s_nxt.seek_done = 1'b1;
    end

    // Request pin is low-active and masked by the disable bit
    s_nxt.irq_n = !(s_nxt.pending && !s_nxt.int_off);      // RULE18
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      // Same task-file defaults that a soft reset restores
      s_r            <= '0;
      s_r.sec_count  <= tf_pkg::RST_SEC_COUNT;
      s_r.sec_number <= tf_pkg::RST_SEC_NUMBER;
      s_r.drive_head <= tf_pkg::RST_DRIVE_HEAD;
      s_r.ready      <= 1'b1;
      s_r.seek_done  <= 1'b1;
      s_r.irq_n      <= 1'b1;
    end
    else
      s_r <= s_nxt;
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // No logic after the registers, so no pin can glitch
  assign pready              = s_r.pready;
  assign prdata              = s_r.prdata;
  assign pslverr             = s_r.pslverr;
  assign interrupt_request_n = s_r.irq_n;
  assign cmd_start           = s_r.start;
  assign cmd_kind            = s_r.kind;
  assign cmd_param           = s_r.param;

endmodule : disk_task_file_status_control

`default_nettype wire

// ==== disk_task_file_monitor.sv ====
`timescale 1ns/1ps
`default_nettype none

// ------------------------------------------------------------
// Port checker for the task-file status and control block
// ------------------------------------------------------------
module disk_task_file_monitor (
  input wire logic               pclk,
  input wire logic               presetn,
  input wire logic               psel,
  input wire logic               penable,
  input wire logic               pwrite,
  input wire logic [7:0]         paddr,
  input wire logic [31:0]        pwdata,
  input wire logic               pready,
  input wire logic [31:0]        prdata,
  input wire logic               pslverr,
  input wire logic               interrupt_request_n,
  input wire logic               cmd_start,
  input wire tf_pkg::cmd_class_t cmd_kind,
  input wire tf_pkg::cmd_param_t cmd_param
);
  default clocking mon_cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // Command start is a strobe caused by a command write one or two edges earlier
  a_start_single: assert property (cmd_start |=> !cmd_start)
    else $error("command start held for more than one cycle");
  a_start_cause: assert property (cmd_start |->
    $past(psel && !penable && pwrite && paddr == tf_pkg::OFF_STATUS)
    || $past(psel && !penable && pwrite && paddr == tf_pkg::OFF_STATUS, 2))
    else $error("command start without a command write");
  a_kind_shown: assert property (cmd_start |-> ##[0:1] cmd_kind != tf_pkg::CC_NONE)
    else $error("accepted command shows no class");
  // Bus answers exactly one cycle after setup
  a_ready_answer: assert property (psel && !penable |=> pready)
    else $error("no ready in the access cycle");
  a_err_with_ready: assert property (pslverr |-> pready)
    else $error("slave error outside an answer");
  a_data_idle: assert property (!pready |-> prdata == 32'h0)
    else $error("read data driven outside an answer");
  a_index_zero: assert property (pready && !pwrite && (paddr == tf_pkg::OFF_STATUS
    || paddr == tf_pkg::OFF_SHADOW) |-> prdata[tf_pkg::ST_INDEX] == 1'h0)
    else $error("index bit read as one");
  a_shadow_keep: assert property (psel && !penable && !pwrite
    && paddr == tf_pkg::OFF_SHADOW && !interrupt_request_n |=> !interrupt_request_n)
    else $error("shadow status read dropped the request");
  // A new request only ever follows a write taken on the bus
  a_irq_cause: assert property ($fell(interrupt_request_n) |-> $past(psel && pwrite))
    else $error("request raised without a write");

  c_command: cover property (cmd_start);
  c_irq: cover property ($fell(interrupt_request_n));
  c_slverr: cover property (pslverr);
endmodule : disk_task_file_monitor

bind disk_task_file_status_control disk_task_file_monitor mon (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
  .interrupt_request_n(interrupt_request_n), .cmd_start(cmd_start),
  .cmd_kind(cmd_kind), .cmd_param(cmd_param)
);

`default_nettype wire

// ==== host_bus_model.sv ====
`timescale 1ns/1ps
`default_nettype none

// ------------------------------------------------------------
// Host controller model: register bus master
// ------------------------------------------------------------
module host_bus_model (
  input  wire logic        pclk,
  input  wire logic        pready,
  input  wire logic [31:0] prdata,
  input  wire logic        pslverr,
  output var  logic        psel,
  output var  logic        penable,
  output var  logic        pwrite,
  output var  logic [7:0]  paddr,
  output var  logic [31:0] pwdata,
  output var  logic        hung
);
  initial
  begin
    psel = 1'h0;
    penable = 1'h0;
    pwrite = 1'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    hung = 1'h0;
  end

  // One transfer; a missing answer is flagged rather than waited for forever
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
    int n;
    @(posedge pclk);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'h1 && n < 16);
    if (pready !== 1'h1)
      hung <= 1'h1;
    q = prdata;
    e = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    // Released lines show no stale value
    paddr <= ~a;
    pwdata <= ~d;
  endtask : xfer
endmodule : host_bus_model

`default_nettype wire

// ==== test_disk_task_file_status_control.sv ====
`timescale 1ns/1ps
`default_nettype none

// ------------------------------------------------------------
// Testbench
// ------------------------------------------------------------
module test_disk_task_file_status_control;
  logic               pclk;
  logic               presetn;
  logic               psel;
  logic               penable;
  logic               pwrite;
  logic [7:0]         paddr;
  logic [31:0]        pwdata;
  logic               pready;
  logic [31:0]        prdata;
  logic               pslverr;
  logic               interrupt_request_n;
  logic               cmd_start;
  logic               hung;
  tf_pkg::cmd_class_t cmd_kind;
  tf_pkg::cmd_param_t cmd_param;
  int                 error_cnt = 0;
  int                 compares = 0;
  int                 starts = 0;

  disk_task_file_status_control DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .interrupt_request_n(interrupt_request_n),
    .cmd_start(cmd_start), .cmd_kind(cmd_kind), .cmd_param(cmd_param));
  host_bus_model host (.pclk(pclk), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .hung(hung));

  always #12.5 pclk = ~pclk;

  // Count accepted commands; a lost bus answer ends the run
  always @(posedge pclk)
  begin
    if (cmd_start === 1'h1)
      starts++;
    if (hung === 1'h1)
    begin
      error_cnt++;
      report_and_stop();
    end
  end

  task automatic report_and_stop();
    $display("Comparisons %0d, mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : report_and_stop

  task automatic check_val(input logic [45:0] got, input logic [45:0] exp);
    compares++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("MISMATCH t=%0t got %0h expected %0h", $time, got, exp);
    end
  endtask : check_val

  task automatic check_param(input tf_pkg::cmd_param_t got, input tf_pkg::cmd_param_t exp);
    compares++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("MISMATCH t=%0t param %0h expected %0h", $time, got, exp);
    end
  endtask : check_param

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic        e;
    host.xfer(1'h1, a, d, q, e);
  endtask : wr

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] x);
    logic [31:0] q;
    logic        e;
    host.xfer(1'h0, a, 32'h0, q, e);
    check_val(46'(q & m), 46'(x));
  endtask : rd_chk

  // Command write; class and parameters settle a cycle later
  task automatic cmd(input logic [7:0] c);
    wr(tf_pkg::OFF_STATUS, 32'(c));
    repeat (2) @(posedge pclk);
  endtask : cmd

  logic [7:0]         codes [10] = '{8'h20, 8'h21, 8'h30, 8'h31, 8'h38,
                                     8'hC4, 8'hC5, 8'hCD, 8'hEF, 8'h70};
  tf_pkg::cmd_class_t kinds [10] = '{tf_pkg::CC_READ, tf_pkg::CC_READ, tf_pkg::CC_WRITE,
    tf_pkg::CC_WRITE, tf_pkg::CC_WRITE, tf_pkg::CC_READ, tf_pkg::CC_WRITE,
    tf_pkg::CC_WRITE, tf_pkg::CC_FEAT, tf_pkg::CC_SEEK};

  initial
  begin
    logic [31:0] q;
    logic        e;
    tf_pkg::cmd_param_t exp_p;
    int          n0;
    pclk = 1'h0;
    presetn = 1'h0;
    repeat (6) @(posedge pclk);
    presetn <= 1'h1;
    rd_chk(tf_pkg::OFF_STATUS, 32'hFFFFFFFF, 32'h50);
    rd_chk(tf_pkg::OFF_SHADOW, 32'hFFFFFFFF, 32'h50);
    host.xfer(1'h0, 8'hFC, 32'h0, q, e);
    check_val(46'(e), 46'h1);
    wr(tf_pkg::OFF_MODE, 32'h81);
    // Parameters first, command last; count zero and a feature byte not always valid
    wr(tf_pkg::OFF_SEC_COUNT, 32'h00);
    wr(tf_pkg::OFF_SEC_NUMBER, 32'h11);
    wr(tf_pkg::OFF_CYL_LOW, 32'h22);
    wr(tf_pkg::OFF_CYL_HIGH, 32'h33);
    wr(tf_pkg::OFF_DRIVE_HEAD, 32'hE5);
    wr(tf_pkg::OFF_FEATURE, 32'h5A);
    for (int i = 0; i < 10; i++)
    begin
      exp_p = (kinds[i] == tf_pkg::CC_FEAT) ? {37'h0, 8'h5A, 2'h0} :
              {28'h5332211, (kinds[i] == tf_pkg::CC_SEEK) ? 9'h000 : 9'h100, 10'h001};
      n0 = starts;
      cmd(codes[i]);
      check_val(46'(starts - n0), 46'h1);
      check_val(46'(cmd_kind), 46'(kinds[i]));
      check_param(cmd_param, exp_p);
      rd_chk(tf_pkg::OFF_STATUS, 32'h90, (kinds[i] == tf_pkg::CC_SEEK) ? 32'h80 : 32'h90);
      wr(tf_pkg::OFF_BACKEND, 32'h01);
      check_val(46'(interrupt_request_n), 46'h0);
      rd_chk(tf_pkg::OFF_SHADOW, 32'h10, 32'h10);
      check_val(46'(interrupt_request_n), 46'h0);
      rd_chk(tf_pkg::OFF_STATUS, 32'hFF, 32'h50);
      check_val(46'(interrupt_request_n), 46'h1);
    end
    // Unknown code aborts; index outside 1..3 keeps the request
    wr(tf_pkg::OFF_MODE, 32'h84);
    cmd(8'h00);
    check_val(46'(interrupt_request_n), 46'h0);
    rd_chk(tf_pkg::OFF_STATUS, 32'hFF, 32'h51);
    rd_chk(tf_pkg::OFF_ERROR, 32'h04, 32'h04);
    check_val(46'(interrupt_request_n), 46'h0);
    wr(tf_pkg::OFF_MODE, 32'h81);
    rd_chk(tf_pkg::OFF_STATUS, 32'h01, 32'h01);
    check_val(46'(interrupt_request_n), 46'h1);
    // Data request and corrected data; next command clears request and error
    cmd(8'h20);
    wr(tf_pkg::OFF_BACKEND, 32'h15);
    rd_chk(tf_pkg::OFF_STATUS, 32'hFF, 32'h5C);
    cmd(8'h30);
    wr(tf_pkg::OFF_BACKEND, 32'h01);
    rd_chk(tf_pkg::OFF_STATUS, 32'h09, 32'h00);
    // Interrupt gating; upper control bits carry no meaning
    wr(tf_pkg::OFF_DEV_CTRL, 32'h0A);
    cmd(8'h20);
    wr(tf_pkg::OFF_BACKEND, 32'h01);
    check_val(46'(interrupt_request_n), 46'h1);
    wr(tf_pkg::OFF_DEV_CTRL, 32'hF8);
    check_val(46'(interrupt_request_n), 46'h0);
    // Corrected flag stays up until a soft reset
    rd_chk(tf_pkg::OFF_STATUS, 32'hFF, 32'h54);
    cmd(8'h30);
    wr(tf_pkg::OFF_BACKEND, 32'h09);
    rd_chk(tf_pkg::OFF_STATUS, 32'h21, 32'h21);
    // Soft reset holds busy and refuses commands until released
    wr(tf_pkg::OFF_DEV_CTRL, 32'h0C);
    rd_chk(tf_pkg::OFF_STATUS, 32'h80, 32'h80);
    n0 = starts;
    cmd(8'h20);
    check_val(46'(starts - n0), 46'h0);
    wr(tf_pkg::OFF_DEV_CTRL, 32'h08);
    rd_chk(tf_pkg::OFF_STATUS, 32'hFF, 32'h50);
    rd_chk(tf_pkg::OFF_MODE, 32'hFF, 32'h81);
    report_and_stop();
  end
endmodule : test_disk_task_file_status_control

`default_nettype wire
